// file: design/cgc_pkg.sv
`default_nettype none
package cgc_pkg;

  // Byte addresses of the registers on the Avalon-MM slave.
  localparam logic [4:0] CLOCK_CONTROL_TWO_ADDR    = 5'h00;
  localparam logic [4:0] REFERENCE_TRIM_ADDR       = 5'h04;
  localparam logic [4:0] CLOCK_STATUS_CONTROL_ADDR = 5'h08;
  localparam logic [4:0] EVENT_STATUS_ADDR         = 5'h0c;
  localparam logic [4:0] EVENT_MASK_ADDR           = 5'h10;

  // Field positions in the status and control register.
  localparam int FINE_POS       = 0;
  localparam int OSC_READY_POS  = 1;
  localparam int MODE_LSB_POS   = 2;

  // Event bit positions in the event status and mask registers.
  localparam int EVT_OSC_READY   = 0;
  localparam int EVT_MODE_CHANGE = 1;
  localparam int EVT_WIDTH       = 2;

  // Values after reset and after power-on.
  localparam logic [1:0] BUS_DIVIDER_RESET = 2'h1;
  localparam logic [7:0] TRIM_POWER_ON     = 8'h80;
  localparam logic       FINE_POWER_ON     = 1'h0;

  // Cycles a newly selected source must run before the switch completes.
  localparam int          SWITCH_TIME_NS = 400;
  localparam int          CLOCK_NS       = 100;
  localparam logic [3:0]  SWITCH_CYCLES  = 4'((SWITCH_TIME_NS + CLOCK_NS - 1) / CLOCK_NS);

  // Source-select and active-mode encodings.
  typedef enum logic [1:0] {
    CGC_SRC_LOOP     = 2'h0,
    CGC_SRC_INTERNAL = 2'h1,
    CGC_SRC_EXTERNAL = 2'h2,
    CGC_SRC_RESERVED = 2'h3
  } cgc_source_e;

  // Layout of the second control register, bit 7 first.
  typedef struct packed {
    logic [1:0] busDivider;
    logic       rangeHigh;
    logic       oscHighGainSelect;
    logic       loopPowerDownInBypass;
    logic       extSourceIsCrystal;
    logic       extRefOutputEnable;
    logic       extRefKeepInStop;
  } cgc_ctrl_two_s;

  localparam cgc_ctrl_two_s CTRL_TWO_RESET = '{BUS_DIVIDER_RESET, 1'b0, 1'b0, 1'b0,
                                               1'b0, 1'b0, 1'b0};

  // Oscillator controls handed to the external oscillator.
  typedef struct packed {
    logic highRange;
    logic highGain;
    logic crystalRequest;
    logic enable;
  } cgc_osc_ctrl_s;

endpackage
`default_nettype wire

// file: design/cgc_clock_gen_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - bus divider divides selected clock 1,2,4,8
// - range bit selects oscillator frequency range
// - gain bit selects high-gain or low-power oscillator
// - low-power bit stops loop in bypass unless background debug active
// - crystal bit requests oscillator else external clock
// - auxiliary reference output only while enabled
// - stop keeps external reference under conditions
// - larger trim value lengthens reference period
// - trim bits binary weighted
// - fine bit is smallest period step
// - mode status reports active clock mode
// - mode status updates after switch synchronization
// - oscillator ready set after start-up completes
// - ready cleared only by enable or crystal
// - source select chooses loop, internal, external
// - bus divider write acts immediately
// - unavailable new source keeps previous source
// - reset leaves trim values unchanged
module cgc_clock_gen_ctrl
  import cgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        powerOnReset_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [1:0]  sourceSelect,
  input  wire logic        refIsInternal,
  input  wire logic        backgroundDebugActive,
  input  wire logic        stopMode,
  input  wire logic [2:0]  sourceRunningPin,
  input  wire logic        oscStartupDonePin,
  output logic             busClockTick,
  output cgc_osc_ctrl_s    oscCtrl,
  output logic             loopEnable,
  output logic             extRefAuxEnable,
  output logic             extRefRunInStop,
  output logic      [8:0]  periodCode,
  output logic             irq
);

  // Divide mask for a divider code: tick when the low bits are all ones.
  function automatic logic [2:0] divMaskOf(input logic [1:0] code);
    divMaskOf = 3'((4'h1 << code) - 4'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  cgc_ctrl_two_s            ctrlTwo;
  logic [7:0]               trimValue;
  logic                     finePeriodAdjust;
  logic                     oscillatorReady;
  cgc_source_e              activeModeStatus;
  logic [EVT_WIDTH-1:0]     eventStatus;
  logic [EVT_WIDTH-1:0]     eventMask;
  logic                     served;
  logic [2:0]               divCount;
  logic [3:0]               switchCount;
  logic                     lastExtMode;
  logic [2:0]               runSync1;
  logic [2:0]               runSync2;
  logic                     oscSync1;
  logic                     oscSync2;
  cgc_source_e              targetSource;
  logic                     targetRunning;
  logic                     extModeNow;
  logic                     oscReadySet;
  logic                     oscReadyClear;
  logic                     accept;
  logic                     wrCtrl;
  logic                     wrTrim;
  logic                     wrStatus;
  logic                     wrMask;
  logic                     rdEvents;
  logic [EVT_WIDTH-1:0]     eventPulse;
  logic [31:0]              next_readdata;

  typedef enum logic {CGC_SW_IDLE = 1'b0, CGC_SW_WAIT = 1'b1} cgc_switch_e;
  cgc_switch_e switchState;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state, then the access completes.
  // The extra cycle lets read data come from a flip-flop.
  assign waitrequest = (read | write) & ~served;
  assign accept      = (read | write) & served;
  assign wrCtrl      = accept & write & (address == CLOCK_CONTROL_TWO_ADDR);
  assign wrTrim      = accept & write & (address == REFERENCE_TRIM_ADDR);
  assign wrStatus    = accept & write & (address == CLOCK_STATUS_CONTROL_ADDR);
  assign wrMask      = accept & write & (address == EVENT_MASK_ADDR);
  assign rdEvents    = accept & read & (address == EVENT_STATUS_ADDR);

  // Tracks the wait state of the current access.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      served <= 1'b0;
    end else begin
      served <= (read | write) & ~served;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    next_readdata = 32'h0;
    unique case (address)
      CLOCK_CONTROL_TWO_ADDR:    next_readdata[7:0] = ctrlTwo;
      REFERENCE_TRIM_ADDR:       next_readdata[7:0] = trimValue;
      CLOCK_STATUS_CONTROL_ADDR: next_readdata[3:0] = {activeModeStatus, oscillatorReady,
                                                       finePeriodAdjust};
      EVENT_STATUS_ADDR:         next_readdata[EVT_WIDTH-1:0] = eventStatus;
      EVENT_MASK_ADDR:           next_readdata[EVT_WIDTH-1:0] = eventMask;
      default:                   next_readdata = 32'h0;
    endcase
  end

  // Read data is captured during the wait state and stands at completion.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0;
    end else if (read & ~served) begin
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second control register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrlTwo <= CTRL_TWO_RESET;
    end else if (wrCtrl) begin
      ctrlTwo <= cgc_ctrl_two_s'(writedata[7:0]);
    end
  end

  // Trim values survive a plain reset; only power-on sets them.
  always_ff @(posedge clock or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      trimValue        <= TRIM_POWER_ON;
      finePeriodAdjust <= FINE_POWER_ON;
    end else begin
      if (wrTrim) begin
        trimValue <= writedata[7:0];
      end
      if (wrStatus) begin
        finePeriodAdjust <= writedata[FINE_POS];
      end
    end
  end

  // Fine bit is the least significant step below the trim value.
  assign periodCode = {trimValue, finePeriodAdjust};

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock divider; the divider field acts on the very next tick.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divCount <= 3'h0;
    end else begin
      divCount <= divCount + 3'h1;
    end
  end

  assign busClockTick = (divCount & divMaskOf(ctrlTwo.busDivider))
                        == divMaskOf(ctrlTwo.busDivider);

  ////////////////////////////////////////////////////////////////////////////
  // Source running indications come from other clock domains.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      runSync1 <= 3'h0;
      runSync2 <= 3'h0;
      oscSync1 <= 1'b0;
      oscSync2 <= 1'b0;
    end else begin
      runSync1 <= sourceRunningPin;
      runSync2 <= runSync1;
      oscSync1 <= oscStartupDonePin;
      oscSync2 <= oscSync1;
    end
  end

  // The reserved code falls back to the loop output.
  assign targetSource = (sourceSelect == CGC_SRC_RESERVED) ? CGC_SRC_LOOP
                        : cgc_source_e'(sourceSelect);
  assign targetRunning = runSync2[targetSource];

  ////////////////////////////////////////////////////////////////////////////
  // Clock switch: the new source must run for several cycles first.
  // A source that never runs leaves the previous mode in place.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      switchState      <= CGC_SW_IDLE;
      switchCount      <= 4'h0;
      activeModeStatus <= CGC_SRC_LOOP;
    end else begin
      unique case (switchState)
        CGC_SW_IDLE: begin
          switchCount <= 4'h0;
          if (targetSource != activeModeStatus) begin
            switchState <= CGC_SW_WAIT;
          end
        end
        CGC_SW_WAIT: begin
          if (targetSource == activeModeStatus) begin
            switchState <= CGC_SW_IDLE;
          end else if (!targetRunning) begin
            switchCount <= 4'h0;
          end else if (switchCount == SWITCH_CYCLES) begin
            activeModeStatus <= targetSource;
            switchState      <= CGC_SW_IDLE;
          end else begin
            switchCount <= switchCount + 4'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator and loop controls.
  // External reference is in use in engaged-external and bypass-external.
  assign extModeNow = (activeModeStatus == CGC_SRC_EXTERNAL)
                      | ((activeModeStatus == CGC_SRC_LOOP) & ~refIsInternal);
  assign oscCtrl.highRange      = ctrlTwo.rangeHigh;
  assign oscCtrl.highGain       = ctrlTwo.oscHighGainSelect;
  assign oscCtrl.crystalRequest = ctrlTwo.extSourceIsCrystal;
  assign oscCtrl.enable         = stopMode ? extRefRunInStop
                                  : (ctrlTwo.extRefOutputEnable | extModeNow);
  assign loopEnable = ~stopMode & ~(ctrlTwo.loopPowerDownInBypass
                      & (activeModeStatus != CGC_SRC_LOOP)
                      & ~backgroundDebugActive);
  assign extRefAuxEnable = ctrlTwo.extRefOutputEnable
                           & (~stopMode | extRefRunInStop);

  // Remembers whether an external mode was active before stop.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lastExtMode <= 1'b0;
    end else if (!stopMode) begin
      lastExtMode <= extModeNow;
    end
  end

  assign extRefRunInStop = ctrlTwo.extRefKeepInStop
                           & (ctrlTwo.extRefOutputEnable | lastExtMode);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator ready flag; a set in the clearing cycle wins.
  assign oscReadySet   = ctrlTwo.extSourceIsCrystal
                         & (ctrlTwo.extRefOutputEnable | extModeNow) & oscSync2;
  assign oscReadyClear = ~ctrlTwo.extRefOutputEnable | ~ctrlTwo.extSourceIsCrystal;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oscillatorReady <= 1'b0;
    end else if (oscReadySet) begin
      oscillatorReady <= 1'b1;
    end else if (oscReadyClear) begin
      oscillatorReady <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events: ready rising and a completed mode change.
  assign eventPulse[EVT_OSC_READY]   = oscReadySet & ~oscillatorReady;
  assign eventPulse[EVT_MODE_CHANGE] = (switchState == CGC_SW_WAIT) & targetRunning
                                       & (switchCount == SWITCH_CYCLES)
                                       & (targetSource != activeModeStatus);

  // Sticky bits cleared by a read; a new event in that cycle survives.
  // Only bits that the read reported are cleared: an event in the wait cycle
  // came after the data was captured and would otherwise be lost unseen.
  for (genvar i = 0; i < EVT_WIDTH; i++) begin : g_event
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        eventStatus[i] <= 1'b0;
      end else if (eventPulse[i]) begin
        eventStatus[i] <= 1'b1;
      end else if (rdEvents && readdata[i]) begin
        eventStatus[i] <= 1'b0;
      end
    end
  end

  // Event mask register.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eventMask <= '0;
    end else if (wrMask) begin
      eventMask <= writedata[EVT_WIDTH-1:0];
    end
  end

  assign irq = |(eventStatus & eventMask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence ctrlWrite;
    wrCtrl;
  endsequence

  sequence switchDone;
    (switchState == CGC_SW_WAIT) && (switchCount == SWITCH_CYCLES) && targetRunning;
  endsequence

  divide_by_one_a: assert property ((ctrlTwo.busDivider == 2'h0) |-> busClockTick)
    else $error("Bus tick missing at divide by one.");
  // A new divider code acts at once, so the spacing only holds while the code stays.
  divide_by_eight_a: assert property ((ctrlTwo.busDivider == 2'h3) && busClockTick
    |=> (!busClockTick || (ctrlTwo.busDivider != 2'h3)) [*7])
    else $error("Bus tick too soon at divide by eight.");
  range_follows_a: assert property (ctrlWrite
    |=> oscCtrl.highRange == $past(writedata[5])
    && oscCtrl.highGain == $past(writedata[4])) else $error("Oscillator range or gain wrong.");
  loop_gated_a: assert property (ctrlTwo.loopPowerDownInBypass && !backgroundDebugActive
    && activeModeStatus != CGC_SRC_LOOP |-> !loopEnable) else $error("Loop ran in bypass.");
  aux_gated_a: assert property (!ctrlTwo.extRefOutputEnable |-> !extRefAuxEnable)
    else $error("Auxiliary reference enabled while off.");
  stop_keep_a: assert property (stopMode && !ctrlTwo.extRefKeepInStop
    |-> !oscCtrl.enable) else $error("External reference kept in stop.");
  trim_code_a: assert property (wrTrim |=> periodCode[8:1] == $past(writedata[7:0]))
    else $error("Period code does not follow trim.");
  mode_after_sync_a: assert property ($changed(activeModeStatus) |-> $past(switchCount)
    == SWITCH_CYCLES && $past(targetRunning)) else $error("Mode changed before switch.");
  mode_switch_a: assert property (switchDone and (targetSource != activeModeStatus)
    |=> activeModeStatus == $past(targetSource)) else $error("Mode status not updated.");
  ready_clear_a: assert property ($fell(oscillatorReady) |-> $past(oscReadyClear))
    else $error("Ready flag cleared without cause.");
  status_upper_a: assert property (accept && read
    && address == CLOCK_STATUS_CONTROL_ADDR |-> readdata[31:4] == 28'h0)
    else $error("Status upper bits not zero.");

endmodule // cgc_clock_gen_ctrl
`default_nettype wire

// file: test/tb_clock_gen_ctrl_trim_status.sv
`timescale 1ns/1ns
`default_nettype none
module tb_clock_gen_ctrl_trim_status
  import cgc_pkg::*;
();
  logic          clock = 1'b0;
  logic          reset_n, powerOnReset_n, read, write, waitrequest;
  logic          refIsInternal, backgroundDebugActive, stopMode, oscStartupDonePin;
  logic          busClockTick, loopEnable, extRefAuxEnable, extRefRunInStop, irq;
  logic [4:0]    address;
  logic [31:0]   writedata, readdata, rdat;
  logic [1:0]    sourceSelect;
  logic [2:0]    sourceRunningPin;
  logic [8:0]    periodCode;
  cgc_osc_ctrl_s oscCtrl;
  int            error_cnt, n_checks;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz and the device under test.
  always #50 clock = ~clock;

  cgc_clock_gen_ctrl i_dut (.clock(clock), .reset_n(reset_n), .powerOnReset_n(powerOnReset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .sourceSelect(sourceSelect),
    .refIsInternal(refIsInternal), .backgroundDebugActive(backgroundDebugActive),
    .stopMode(stopMode), .sourceRunningPin(sourceRunningPin),
    .oscStartupDonePin(oscStartupDonePin), .busClockTick(busClockTick), .oscCtrl(oscCtrl),
    .loopEnable(loopEnable), .extRefAuxEnable(extRefAuxEnable),
    .extRefRunInStop(extRefRunInStop), .periodCode(periodCode), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus helpers.
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until waitrequest is seen low at a rising edge, then released.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      give_verdict;
    end
    rdat = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Status fields move only after synchronisation, so they are polled under a bound.
  task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((rdat & m) !== e && n < 40);
    if (n >= 40) begin
      error_cnt++;
      give_verdict;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    rd(CLOCK_CONTROL_TWO_ADDR);    chk(rdat, 32'h40);
    rd(REFERENCE_TRIM_ADDR);       chk(rdat, 32'h80);
    rd(CLOCK_STATUS_CONTROL_ADDR); chk(rdat, 32'h00);
    rd(EVENT_STATUS_ADDR);         chk(rdat, 32'h00);
    rd(EVENT_MASK_ADDR);           chk(rdat, 32'h00);
    wr(5'h14, 32'hff);
    rd(5'h14);                     chk(rdat, 32'h00);
    chk(32'(periodCode), 32'h100);
    $display("test reset done");
  endtask

  // A window of 32 cycles holds a whole number of periods for every divider code.
  task automatic t_div;
    int cnt;
    for (int c = 0; c < 4; c++) begin
      wr(CLOCK_CONTROL_TWO_ADDR, 32'(c) << 6);
      repeat (8) @(posedge clock);
      cnt = 0;
      repeat (32) begin
        @(posedge clock);
        if (busClockTick === 1'b1) cnt++;
      end
      chk(32'(cnt), 32'd32 >> c);
    end
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h40);
    $display("test divider done");
  endtask

  // One bit at a time, so that swapped wiring between fields shows up.
  task automatic t_bits;
    for (int i = 0; i < 4; i++) begin
      wr(CLOCK_CONTROL_TWO_ADDR,
         32'h40 | (i == 0 ? 32'h20 : i == 1 ? 32'h10 : i == 2 ? 32'h04 : 32'h02));
      @(negedge clock);
      chk(32'({oscCtrl.highRange, oscCtrl.highGain, oscCtrl.crystalRequest, extRefAuxEnable}),
          32'h8 >> i);
    end
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h40);
    $display("test control bits done");
  endtask

  task automatic t_mode;
    sourceRunningPin <= 3'b011;
    sourceSelect <= 2'h1;
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat & 32'h0c, 32'h00);
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h04);
    chk(rdat & 32'h0c, 32'h04);
    sourceSelect <= 2'h2;
    repeat (40) @(posedge clock);
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat & 32'h0c, 32'h04);
    sourceRunningPin <= 3'b111;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h08);
    chk(rdat & 32'h0c, 32'h08);
    sourceSelect <= 2'h1;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h04);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h48);
    @(negedge clock);                        chk(32'(loopEnable), 32'h0);
    @(posedge clock);
    backgroundDebugActive <= 1'b1;
    @(negedge clock);                        chk(32'(loopEnable), 32'h1);
    @(posedge clock);
    backgroundDebugActive <= 1'b0;
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h40);
    @(negedge clock);                        chk(32'(loopEnable), 32'h1);
    @(posedge clock);
    sourceSelect <= 2'h0;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h00);
    // The reserved code must fall back to the loop output.
    sourceSelect <= 2'h1;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h04);
    sourceSelect <= 2'h3;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h0c, 32'h00);
    chk(rdat & 32'h0c, 32'h00);
    sourceSelect <= 2'h0;
    $display("test mode switch done");
  endtask

  task automatic stop_case(input logic [31:0] c, input logic ri, input logic e);
    wr(CLOCK_CONTROL_TWO_ADDR, c);
    refIsInternal <= ri;
    repeat (3) @(posedge clock);
    stopMode <= 1'b1;
    @(negedge clock);
    chk(32'(extRefRunInStop), 32'(e));
    chk(32'(oscCtrl.enable), 32'(e));
    @(posedge clock);
    stopMode <= 1'b0;
  endtask

  // Loop mode with the external reference counts as engaged-external before stop.
  task automatic t_stop;
    stop_case(32'h41, 1'b0, 1'b1);
    stop_case(32'h41, 1'b1, 1'b0);
    stop_case(32'h43, 1'b1, 1'b1);
    stop_case(32'h42, 1'b0, 1'b0);
    stop_case(32'h40, 1'b1, 1'b0);
    refIsInternal <= 1'b1;
    $display("test stop done");
  endtask

  task automatic t_osc;
    rd(EVENT_STATUS_ADDR);                   chk(rdat & 32'h02, 32'h02);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h46);
    oscStartupDonePin <= 1'b1;
    poll(CLOCK_STATUS_CONTROL_ADDR, 32'h02, 32'h02);
    chk(rdat & 32'h02, 32'h02);
    @(negedge clock);                        chk(32'(irq), 32'h0);
    wr(EVENT_MASK_ADDR, 32'h01);
    @(negedge clock);                        chk(32'(irq), 32'h1);
    rd(EVENT_STATUS_ADDR);                   chk(rdat, 32'h01);
    @(negedge clock);                        chk(32'(irq), 32'h0);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h56);
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat & 32'h02, 32'h02);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h42);
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat & 32'h02, 32'h00);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h40);
    $display("test oscillator ready done");
  endtask

  // A control reset in mid-run must leave both trim values alone.
  task automatic t_trim;
    wr(REFERENCE_TRIM_ADDR, 32'h5a);
    wr(CLOCK_STATUS_CONTROL_ADDR, 32'hf3);
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat, 32'h01);
    @(negedge clock);                        chk(32'(periodCode), 32'h0b5);
    wr(CLOCK_CONTROL_TWO_ADDR, 32'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(REFERENCE_TRIM_ADDR);                 chk(rdat, 32'h5a);
    rd(CLOCK_STATUS_CONTROL_ADDR);           chk(rdat, 32'h01);
    rd(CLOCK_CONTROL_TWO_ADDR);              chk(rdat, 32'h40);
    $display("test trim done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: both resets held for five cycles, then every scenario in turn.
  initial begin
    reset_n = 1'b0;
    powerOnReset_n = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    sourceSelect = 2'h0;
    refIsInternal = 1'b1;
    backgroundDebugActive = 1'b0;
    stopMode = 1'b0;
    sourceRunningPin = 3'b001;
    oscStartupDonePin = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    powerOnReset_n <= 1'b1;
    t_reset;
    t_div;
    t_bits;
    t_mode;
    t_stop;
    t_osc;
    t_trim;
    give_verdict;
  end
endmodule // tb_clock_gen_ctrl_trim_status
`default_nettype wire
